// ---- verif/sac_ctrl_port_bench.sv ----
// bench: spi host, converter stand-in and reference model
`timescale 1ns/1ps
module sac_ctrl_port_bench;
  import sac_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b0;
  logic pd = 1'b0;
  sac_result_t res = '0;
  logic sclk, ss_n, mosi, miso, start, dr, gp;
  sac_src_t src;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  bit buf_on = 1'b0;
  logic [31:0] seed = 32'h0000005B;
  logic [15:0] wd[4];
  logic [15:0] rd[4];
  logic [11:0] reg_m[8];
  logic [11:0] fq[$];
  sac_src_t src_q[$];
  always #50 clk_i = ~clk_i;
  sac_ctrl_port #(.TICK_CYC(8), .PULSE_CYC(4)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(),
    .power_down_i(pd), .conv_start_o(start), .conv_src_o(src), .conv_result_i(res),
    .data_ready_out_o(dr), .general_pin_one_o(gp));
  sac_host_model i_host (.sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic x(input logic [15:0] cmd, input int k);
    i_host.frame(cmd, k, wd, rd);
    repeat (6) tick();
  endtask : x
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // converter stand-in: each start is answered three cycles on
  always begin
    tick();
    while (start) begin
      repeat (3) tick();
      seed = xs(seed);
      res = {1'b1, seed[11:0]};
      src_q.push_back(src);
      reg_m[src] = seed[11:0];
      if (buf_on) fq.push_back(seed[11:0]);
      tick();
      res.valid = 1'b0;
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    #1 reset_i = 1'b1;
    repeat (3) tick();
    reset_i = 1'b0;
    repeat (2) tick();
    wd[0] = 16'h1800;
    x(16'h0800, 1);
    for (n = 0; n < 300 && src_q.size() < 3; n++) tick();
    for (n = 0; n < 3; n++) chk(16'(src_q[n]), 16'(n + 1));
    x(16'h80A0, 4);
    chk(rd[0], {4'h0, reg_m[SRC_BAT]});
    chk(rd[2], {4'h0, reg_m[SRC_AUX_INPUT_ONE]});
    chk(rd[3], {4'h0, reg_m[SRC_AUX_INPUT_TWO]});
    seed = xs(seed);
    wd = '{seed[15:0], seed[31:16], 16'h0000, 16'h0000};
    x(16'h17C0, 3);
    x(16'h97C0, 3);
    chk(rd[0], wd[0]);
    chk(rd[1], wd[1]);
    chk(rd[2], WORD_ONES);
    $display("scan and paging done");
    // single shot, trigger level 3, select still holds the scan list
    buf_on = 1'b1;
    wd[0] = 16'hA003;
    x(16'h0840, 1);
    for (n = 0; n < 2000 && dr !== 1'b1; n++) tick();
    chk(16'(fq.size()), 16'h0003);
    repeat (60) tick();
    chk(16'(fq.size()), 16'h0003);
    x(16'h9800, 3);
    for (n = 0; n < 3; n++) chk({4'h0, rd[n][11:0]}, {4'h0, fq[n]});
    chk(16'(fq.size() > 3), 16'h0001);
    wd[0] = 16'h0000;
    x(16'h0800, 1);
    repeat (20) tick();
    buf_on = 1'b0;
    wd[0] = 16'hA003;
    x(16'h0840, 1);
    x(16'h9800, 2);
    chk(rd[1] & 16'hC000, 16'h8000);
    fq.delete();
    buf_on = 1'b1;
    wd[0] = 16'hE003;
    x(16'h0840, 1);
    wd[0] = 16'h1800;
    x(16'h0800, 1);
    for (n = 0; n < 500 && dr !== 1'b1; n++) tick();
    repeat (8) tick();
    chk(16'(dr), 16'h0000);
    for (n = 0; n < 2000 && fq.size() < 70; n++) tick();
    wd[0] = 16'h0000;
    x(16'h0800, 1);
    repeat (20) tick();
    x(16'h9800, 1);
    chk(rd[0], {4'h4, fq[fq.size() - 64]});
    $display("buffer done");
    // narrow window on aux one only, interval of four ticks
    wd = '{16'h0010, 16'h0000, 16'h0FFF, 16'h0000};
    x(16'h0900, 4);
    wd = '{16'h8200, 16'h0003, 16'h0000, 16'h0000};
    src_q.delete();
    x(16'h0980, 2);
    for (n = 0; n < 3000 && gp !== 1'b1; n++) tick();
    chk(16'(gp), 16'h0001);
    chk(16'(src_q[0]), 16'h0002);
    x(16'h8980, 1);
    chk(rd[0] & 16'h8300, 16'h8300);
    pd = 1'b1;
    repeat (40) tick();
    n = src_q.size();
    repeat (80) tick();
    chk(16'(src_q.size() - n), 16'h0000);
    x(16'h8980, 1);
    chk(rd[0] & 16'h8200, 16'h8200);
    pd = 1'b0;
    $display("auto aux done");
    reset_i = 1'b1;
    repeat (3) tick();
    reset_i = 1'b0;
    repeat (2) tick();
    x(16'h8980, 1);
    chk(rd[0], WORD_ZERO);
    $display("reset done");
    end_of_test();
  end
endmodule : sac_ctrl_port_bench

// ---- verif/sac_host_model.sv ----
// spi host stand-in, clock idle low, data driven on rising edges
`timescale 1ns/1ps
module sac_host_model (
  output logic     sclk_o,
  output logic     ss_n_o,
  output logic     mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b0;
    mosi_o = 1'b0;
    #1 ss_n_o = 1'b1;
  end
  task automatic word(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--) begin
      #40 sclk_o = 1'b1;
      mosi_o = d[i];
      #40 sclk_o = 1'b0;
      q[i] = miso_i;
    end
  endtask : word
  task automatic frame(input logic [15:0] c, input int k, input logic [15:0] wd[4], output logic [15:0] rd[4]);
    logic [15:0] d;
    #100 ss_n_o = 1'b0;
    word({c[15:5], 5'h00}, d);
    if (c[15]) #1000;
    for (int j = 0; j < k; j++) word(wd[j], rd[j]);
    #40 ss_n_o = 1'b1;
    // a released line must not keep showing the last bit
    mosi_o = ~mosi_o;
  endtask : frame
endmodule : sac_host_model

// ---- verif/sac_monitor.sv ----
// checker on the control port pins
`timescale 1ns/1ps
module sac_monitor
  import sac_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        spi_ss_n_i,
  input wire logic        spi_miso_oe_o,
  input wire logic        power_down_i,
  input wire logic        conv_start_o,
  input wire sac_src_t    conv_src_o,
  input wire sac_result_t conv_result_i,
  input wire logic        data_ready_out_o,
  input wire logic        general_pin_one_o
);
  logic [15:0] hi_ff;
  logic [3:0]  age_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  //==========
  // helpers: the pulse is far longer than a repetition may unroll
  always_ff @(posedge clk_i) begin
    hi_ff <= (reset_i || !general_pin_one_o) ? 16'h0000 : hi_ff + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) age_ff <= 4'hF;
    else if (conv_result_i.valid) age_ff <= 4'h0;
    else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
  end
  //==========
  // properties
  property p_oe; spi_miso_oe_o == !spi_ss_n_i; endproperty
  a_oe: assert property (p_oe) else $error("miso enable off");
  property p_start; conv_start_o |=> !conv_start_o; endproperty
  a_start: assert property (p_start) else $error("long start");
  property p_rst;
    disable iff (1'b0) reset_i |=> !conv_start_o && !data_ready_out_o && !general_pin_one_o && conv_src_o == SRC_NONE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_pd; power_down_i [*6] |-> !conv_start_o; endproperty
  a_pd: assert property (p_pd) else $error("start in power down");
  property p_gp_max; general_pin_one_o |-> hi_ff < 16'(PULSE_CYC); endproperty
  a_gp_max: assert property (p_gp_max) else $error("pulse too long");
  property p_gp_len; $fell(general_pin_one_o) |-> hi_ff == 16'(PULSE_CYC); endproperty
  a_gp_len: assert property (p_gp_len) else $error("pulse too short");
  property p_dr; $rose(data_ready_out_o) |-> age_ff <= 4'h4; endproperty
  a_dr: assert property (p_dr) else $error("ready without result");
  property p_gp; $rose(general_pin_one_o) |-> age_ff <= 4'h5; endproperty
  a_gp: assert property (p_gp) else $error("pulse without result");
  c_dr: cover property ($rose(data_ready_out_o));
  c_gp: cover property ($rose(general_pin_one_o));
  c_scan: cover property (conv_start_o && conv_src_o == SRC_AUX_INPUT_TWO);
endmodule : sac_monitor

bind sac_ctrl_port sac_monitor #(.PULSE_CYC(PULSE_CYC)) i_mon (
  .clk_i(clk_i), .reset_i(reset_i), .spi_ss_n_i(spi_ss_n_i), .spi_miso_oe_o(spi_miso_oe_o),
  .power_down_i(power_down_i), .conv_start_o(conv_start_o), .conv_src_o(conv_src_o),
  .conv_result_i(conv_result_i), .data_ready_out_o(data_ready_out_o), .general_pin_one_o(general_pin_one_o));

// ---- verilog/sac_ctrl_port.sv ----
// spi control port, auxiliary sequencer and circular result fifo
`timescale 1ns/1ps
module sac_ctrl_port
  import sac_pkg::*;
#(
  parameter int unsigned TICK_CYC  = TICK_CYCLES,
  parameter int unsigned PULSE_CYC = PULSE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_ss_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic        power_down_i,
  output logic             conv_start_o,
  output sac_src_t         conv_src_o,
  input  wire sac_result_t conv_result_i,
  output logic             data_ready_out_o,
  output logic             general_pin_one_o
);
  //==========================================================================
  // link side, runs on the host clock
  //==========================================================================
  logic [3:0]  rx_cnt_ff;
  logic [15:0] rx_sh_ff;
  logic        cmd_done_ff;
  logic        lk_rd_ff;
  logic [3:0]  lk_page_ff;
  logic [6:0]  lk_idx_ff;
  logic [3:0]  tx_cnt_ff;
  logic [15:0] tx_sh_ff;
  logic        miso_ff;
  logic        req_tgl_ff;
  sac_req_t    req_ff;
  logic        lk_fire;
  sac_req_t    nxt_req;
  logic [15:0] rx_word;
  logic [15:0] rd_word_ff;

  assign rx_word = {rx_sh_ff[14:0], spi_mosi_i};

  // slave select high clears the framing, so a command needs a fresh select fall
  always_ff @(negedge spi_sclk_i or posedge spi_ss_n_i) begin
    if (spi_ss_n_i) begin
      rx_cnt_ff   <= BIT_FIRST;
      rx_sh_ff    <= WORD_ZERO;
      cmd_done_ff <= 1'b0;
      lk_rd_ff    <= 1'b0;
      lk_page_ff  <= PAGE_RESULT;
      lk_idx_ff   <= 7'h00;
    end else begin
      rx_cnt_ff <= rx_cnt_ff + 4'h1;
      rx_sh_ff  <= rx_word;
      if (rx_cnt_ff == BIT_LAST) begin
        if (!cmd_done_ff) begin
          cmd_done_ff <= 1'b1;
          lk_rd_ff    <= rx_word[CMD_DIR_BIT];
          lk_page_ff  <= rx_word[CMD_PAGE_MSB:CMD_PAGE_LSB];
          lk_idx_ff   <= {1'b0, rx_word[CMD_IDX_MSB:CMD_IDX_LSB]};
        end else if (!lk_rd_ff) begin
          lk_idx_ff <= sac_idx_inc(lk_idx_ff);
        end
      end else if (rx_cnt_ff == BIT_FIRST && cmd_done_ff && lk_rd_ff) begin
        lk_idx_ff <= sac_idx_inc(lk_idx_ff);
      end
    end
  end

  // reads fetch the next word while the current one shifts out
  always_comb begin
    lk_fire = 1'b0;
    nxt_req = req_ff;
    if (rx_cnt_ff == BIT_LAST && !cmd_done_ff && rx_word[CMD_DIR_BIT]) begin
      lk_fire = 1'b1;
      nxt_req = '{wr: 1'b0, page: rx_word[CMD_PAGE_MSB:CMD_PAGE_LSB],
                  idx: {1'b0, rx_word[CMD_IDX_MSB:CMD_IDX_LSB]}, data: WORD_ZERO};
    end else if (rx_cnt_ff == BIT_LAST && cmd_done_ff && !lk_rd_ff) begin
      lk_fire = 1'b1;
      nxt_req = '{wr: 1'b1, page: lk_page_ff, idx: lk_idx_ff, data: rx_word};
    end else if (rx_cnt_ff == BIT_FIRST && cmd_done_ff && lk_rd_ff) begin
      lk_fire = 1'b1;
      nxt_req = '{wr: 1'b0, page: lk_page_ff, idx: sac_idx_inc(lk_idx_ff), data: WORD_ZERO};
    end
  end

  // toggle plus held payload; the core resets it too so both ends agree
  always_ff @(negedge spi_sclk_i or posedge reset_i) begin
    if (reset_i) begin
      req_tgl_ff <= 1'b0;
      req_ff     <= '0;
    end else if (!spi_ss_n_i && lk_fire) begin
      req_tgl_ff <= ~req_tgl_ff;
      req_ff     <= nxt_req;
    end
  end

  // rd_word_ff is quasi-static: written by the core long before the word boundary
  always_ff @(posedge spi_sclk_i or posedge spi_ss_n_i) begin
    if (spi_ss_n_i) begin
      tx_cnt_ff <= BIT_FIRST;
      tx_sh_ff  <= WORD_ZERO;
      miso_ff   <= 1'b0;
    end else begin
      tx_cnt_ff <= tx_cnt_ff + 4'h1;
      if (tx_cnt_ff == BIT_FIRST && cmd_done_ff && lk_rd_ff) begin
        miso_ff  <= rd_word_ff[WORD_W-1];
        tx_sh_ff <= {rd_word_ff[14:0], 1'b0};
      end else begin
        miso_ff  <= tx_sh_ff[WORD_W-1];
        tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
      end
    end
  end

  assign spi_miso_o    = miso_ff;
  assign spi_miso_oe_o = ~spi_ss_n_i;

  //==========================================================================
  // crossing into the core clock
  //==========================================================================
  logic     tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
  logic     pd_s1_ff, pd_s2_ff;
  logic     req_evt;
  logic     pd_on;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      pd_s1_ff  <= 1'b0;
      pd_s2_ff  <= 1'b0;
    end else begin
      tgl_s1_ff <= req_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      pd_s1_ff  <= power_down_i;
      pd_s2_ff  <= pd_s1_ff;
    end
  end

  assign req_evt = tgl_s2_ff ^ tgl_s3_ff;
  assign pd_on   = pd_s2_ff;

  //==========================================================================
  // register pages
  //==========================================================================
  logic [15:0] ctrl_ff [0:63];
  logic [15:0] audio_ff [0:63];
  logic [11:0] res_ff [0:7];
  logic [11:0] fifo_mem [0:FIFO_DEPTH-1];
  logic        acc_ok, host_wr, host_rd, pop, oor_clear, start_req, buf_reset;
  logic [15:0] rd_val, wr_data;
  sac_src_t    p0_src;
  logic [5:0]  rd_idx_ff, wr_idx_ff, tg_idx_ff;
  logic [6:0]  cnt_ff;
  logic        fifo_empty, fifo_full, oor_ff;

  assign acc_ok    = req_evt && !req_ff.idx[IDX_W];
  assign host_wr   = acc_ok && req_ff.wr;
  assign host_rd   = acc_ok && !req_ff.wr;
  assign pop       = host_rd && req_ff.page == PAGE_BUFFER;
  assign oor_clear = host_rd && req_ff.page == PAGE_AUXCTL && req_ff.idx[5:0] == IDX_MEASCFG;
  assign start_req = host_wr && req_ff.page == PAGE_AUXCTL && req_ff.idx[5:0] == IDX_ADC &&
                     req_ff.data[SEL_MSB:SEL_LSB] != SRC_NONE;
  assign buf_reset = host_wr && req_ff.page == PAGE_AUXCTL && req_ff.idx[5:0] == IDX_BUFMODE &&
                     req_ff.data[BUF_RESET_BIT];
  // the buffer reset bit is a command, it is never stored
  assign wr_data   = (req_ff.idx[5:0] == IDX_BUFMODE) ? (req_ff.data & ~(16'h0001 << BUF_RESET_BIT))
                                                      : req_ff.data;

  always_comb begin
    p0_src = SRC_NONE;
    if (req_ff.idx[5:0] == IDX_BAT) begin
      p0_src = SRC_BAT;
    end else if (req_ff.idx[5:0] == IDX_AUX_INPUT_ONE) begin
      p0_src = SRC_AUX_INPUT_ONE;
    end else if (req_ff.idx[5:0] == IDX_AUX_INPUT_TWO) begin
      p0_src = SRC_AUX_INPUT_TWO;
    end else if (req_ff.idx[5:0] == IDX_TEMP_RESULT_ONE) begin
      p0_src = SRC_TEMP_RESULT_ONE;
    end else if (req_ff.idx[5:0] == IDX_TEMP_RESULT_TWO) begin
      p0_src = SRC_TEMP_RESULT_TWO;
    end
  end

  always_comb begin
    rd_val = WORD_ZERO;
    if (req_ff.idx[IDX_W]) begin
      rd_val = WORD_ONES;
    end else if (req_ff.page == PAGE_RESULT) begin
      rd_val = (p0_src == SRC_NONE) ? WORD_ZERO : {4'h0, res_ff[p0_src]};
    end else if (req_ff.page == PAGE_AUXCTL) begin
      rd_val = ctrl_ff[req_ff.idx[5:0]];
      if (req_ff.idx[5:0] == IDX_BUFMODE) begin
        rd_val[BUF_EMPTY_BIT] = fifo_empty;
        rd_val[BUF_FULL_BIT]  = fifo_full;
      end else if (req_ff.idx[5:0] == IDX_MEASCFG) begin
        rd_val[OOR_FLAG_BIT] = oor_ff;
      end
    end else if (req_ff.page == PAGE_AUDIO) begin
      rd_val = audio_ff[req_ff.idx[5:0]];
    end else if (req_ff.page == PAGE_BUFFER) begin
      rd_val = {fifo_empty, fifo_full, 2'b00, fifo_mem[rd_idx_ff]};
    end
  end

  // registers survive power-down: only reset_i touches them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_word_ff <= WORD_ZERO;
      for (int i = 0; i < 64; i++) begin
        ctrl_ff[i]  <= WORD_ZERO;
        audio_ff[i] <= WORD_ZERO;
      end
    end else begin
      if (host_rd) begin
        rd_word_ff <= rd_val;
      end else if (req_evt && !req_ff.wr) begin
        rd_word_ff <= WORD_ONES;
      end
      if (host_wr && req_ff.page == PAGE_AUXCTL) begin
        ctrl_ff[req_ff.idx[5:0]] <= wr_data;
      end else if (host_wr && req_ff.page == PAGE_AUDIO) begin
        audio_ff[req_ff.idx[5:0]] <= req_ff.data;
      end
    end
  end

  //==========================================================================
  // conversion sequencer
  //==========================================================================
  sac_seq_t   seq_ff;
  sac_src_t   cur_src_ff, sel_src, first_src;
  logic       list_ff, auto_ff, start_pend_ff, auto_due_ff, hold_ff;
  logic       buf_en, buf_cont, auto_en, thr_en, kick, buf_again, res_ok, oor_set;
  logic [5:0] trig_lvl;
  logic [11:0] win_max, win_min;

  assign sel_src   = sac_src_t'(ctrl_ff[IDX_ADC][SEL_MSB:SEL_LSB]);
  assign buf_en    = ctrl_ff[IDX_BUFMODE][BUF_EN_BIT];
  assign buf_cont  = ctrl_ff[IDX_BUFMODE][BUF_CONT_BIT];
  assign trig_lvl  = ctrl_ff[IDX_BUFMODE][TRIG_MSB:TRIG_LSB];
  assign auto_en   = ctrl_ff[IDX_MEASCFG][AUTO_EN_BIT];
  assign thr_en    = ctrl_ff[IDX_MEASCFG][THR_IRQ_EN_BIT];
  assign first_src = (sel_src == SRC_SCAN) ? SRC_BAT : sel_src;
  assign buf_again = buf_en && !hold_ff && sel_src != SRC_NONE;
  assign kick      = !pd_on && seq_ff == SEQ_IDLE && (start_pend_ff || buf_again || auto_due_ff);
  assign res_ok    = seq_ff == SEQ_WAIT && conv_result_i.valid;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq_ff        <= SEQ_IDLE;
      cur_src_ff    <= SRC_NONE;
      list_ff       <= 1'b0;
      auto_ff       <= 1'b0;
      start_pend_ff <= 1'b0;
    end else begin
      if (start_req) begin
        start_pend_ff <= 1'b1;
      end else if (kick && !auto_due_ff) begin
        start_pend_ff <= 1'b0;
      end
      case (seq_ff)
        SEQ_IDLE: begin
          if (kick && auto_due_ff) begin
            seq_ff     <= SEQ_START;
            cur_src_ff <= SRC_AUX_INPUT_ONE;
            list_ff    <= 1'b1;
            auto_ff    <= 1'b1;
          end else if (kick) begin
            seq_ff     <= SEQ_START;
            cur_src_ff <= first_src;
            list_ff    <= sel_src == SRC_SCAN;
            auto_ff    <= 1'b0;
          end
        end
        SEQ_START: seq_ff <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (res_ok && list_ff && cur_src_ff != SRC_AUX_INPUT_TWO && !pd_on) begin
            seq_ff     <= SEQ_START;
            cur_src_ff <= sac_src_t'(cur_src_ff + 3'b001);
          end else if (res_ok) begin
            seq_ff <= SEQ_IDLE;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  assign conv_start_o = seq_ff == SEQ_START;
  assign conv_src_o   = cur_src_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 8; i++) begin
        res_ff[i] <= 12'h000;
      end
    end else if (res_ok) begin
      res_ff[cur_src_ff] <= conv_result_i.data;
    end
  end

  //==========================================================================
  // auto interval, threshold window and pin pulse
  //==========================================================================
  logic [CNT_W-1:0] tick_cnt_ff, pulse_cnt_ff;
  logic [7:0]       ivl_cnt_ff;
  logic             tick_wrap, gpio_ff;

  assign tick_wrap = tick_cnt_ff == CNT_W'(TICK_CYC - 1);
  assign win_max   = (cur_src_ff == SRC_AUX_INPUT_ONE) ? ctrl_ff[IDX_AUX_INPUT_ONE_MAX][11:0] : ctrl_ff[IDX_AUX_INPUT_TWO_MAX][11:0];
  assign win_min   = (cur_src_ff == SRC_AUX_INPUT_ONE) ? ctrl_ff[IDX_AUX_INPUT_ONE_MIN][11:0] : ctrl_ff[IDX_AUX_INPUT_TWO_MIN][11:0];
  assign oor_set   = res_ok && auto_ff && (conv_result_i.data > win_max || conv_result_i.data < win_min);

  // interval is (delay field + 1) ticks; the counters hold during power-down
  always_ff @(posedge clk_i) begin
    if (reset_i || !auto_en) begin
      tick_cnt_ff <= '0;
      ivl_cnt_ff  <= 8'h00;
      auto_due_ff <= 1'b0;
    end else begin
      if (!pd_on) begin
        tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
        if (tick_wrap) begin
          ivl_cnt_ff <= (ivl_cnt_ff == ctrl_ff[IDX_DELAY][DELAY_MSB:DELAY_LSB]) ? 8'h00 : ivl_cnt_ff + 8'h01;
        end
      end
      if (!pd_on && tick_wrap && ivl_cnt_ff == ctrl_ff[IDX_DELAY][DELAY_MSB:DELAY_LSB]) begin
        auto_due_ff <= 1'b1;
      end else if (kick) begin
        auto_due_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oor_ff       <= 1'b0;
      pulse_cnt_ff <= '0;
      gpio_ff      <= 1'b0;
    end else begin
      if (oor_set) begin
        oor_ff <= 1'b1;
      end else if (oor_clear) begin
        oor_ff <= 1'b0;
      end
      if (oor_set && thr_en) begin
        pulse_cnt_ff <= CNT_W'(PULSE_CYC - 1);
        gpio_ff      <= 1'b1;
      end else if (pulse_cnt_ff != '0) begin
        pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
      end else begin
        gpio_ff <= 1'b0;
      end
    end
  end

  assign general_pin_one_o = gpio_ff;

  //==========================================================================
  // circular result fifo
  //==========================================================================
  logic fifo_wr, trig_hit, pop_ok, irq_ff;

  assign fifo_empty = cnt_ff == 7'h00;
  assign fifo_full  = cnt_ff == FIFO_FULL_CNT;
  assign fifo_wr    = res_ok && buf_en && !auto_ff;
  assign trig_hit   = fifo_wr && wr_idx_ff == tg_idx_ff;
  assign pop_ok     = pop && !fifo_empty;

  always_ff @(posedge clk_i) begin
    if (fifo_wr) begin
      fifo_mem[wr_idx_ff] <= conv_result_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || buf_reset) begin
      rd_idx_ff <= FIFO_INIT_IDX;
      wr_idx_ff <= FIFO_INIT_IDX;
      tg_idx_ff <= buf_reset ? req_ff.data[TRIG_MSB:TRIG_LSB] : trig_lvl;
      cnt_ff    <= 7'h00;
      irq_ff    <= 1'b0;
      hold_ff   <= 1'b0;
    end else begin
      if (fifo_wr) begin
        wr_idx_ff <= wr_idx_ff + 6'h01;
      end
      if (pop_ok || (fifo_wr && fifo_full)) begin
        rd_idx_ff <= rd_idx_ff + 6'h01;
      end
      if (fifo_wr && !pop_ok && !fifo_full) begin
        cnt_ff <= cnt_ff + 7'h01;
      end else if (pop_ok && !fifo_wr) begin
        cnt_ff <= cnt_ff - 7'h01;
      end
      if (trig_hit && buf_cont) begin
        tg_idx_ff <= tg_idx_ff + trig_lvl;
      end else if (pop && hold_ff) begin
        tg_idx_ff <= tg_idx_ff + trig_lvl;
      end
      if (trig_hit) begin
        irq_ff <= 1'b1;
      end else if (pop || (fifo_wr && buf_cont)) begin
        irq_ff <= 1'b0;
      end
      if (trig_hit && !buf_cont) begin
        hold_ff <= 1'b1;
      end else if (pop) begin
        hold_ff <= 1'b0;
      end
    end
  end

  assign data_ready_out_o = irq_ff;
endmodule : sac_ctrl_port

// ---- verilog/sac_pkg.sv ----
// constants, types and field layout of the spi control port with auxiliary result fifo
//==============================================================================
// Behaviour
// - auto-aux mode starts an auxiliary measurement each time the programmed interval elapses
// - auto aux result outside min..max window sets a flag, cleared when host reads it
// - with threshold irq enable, out-of-range also pulses general_pin_one high about 2 ms
// - one host write selecting port scan converts battery, aux one, aux two into results
// - buffer mode stores every converted result except auto-aux ones into a 64 entry circular fifo
// - fifo keeps read, write and trigger indices
// - buffer reset puts read and write index at 1, trigger index at trigger level
// - results written reaching trigger level raise the data ready output
// - single shot: wait after trigger; first read drops irq, restarts, advances trigger index
// - continuous: keep converting after trigger and advance trigger index by trigger level
// - continuous: irq drops on next fifo write or on host fifo read, whichever first
// - reading an empty fifo leaves the read index unchanged
// - full fifo overwrites the next entry and advances the read index by one
// - fifo empty and full flags come with each fifo read and in buffer mode register
// - host releases reset after power-up; reset initialises all registers, counters and logic; the spi link is cleared by slave select and fifo memory is not
// - hardware power-down stops conversions but keeps every register value
// - clock idles low; both sides drive data from the first clock edge (mode 1)
// - a command word is only accepted after a falling edge of slave select
// - command word: direction bit 15, page bits 14..11, register index bits 10..5
// - multi-word access auto-increments index to page end, then reads return 0xFFFF
// - full duplex: a word shifts out on miso while one shifts in on mosi
// - registers sit in four pages: aux results, aux control, audio control, buffer
package sac_pkg;
  // time base
  localparam int CLK_FREQ_KHZ  = 10000;
  localparam int TICK_TIME_MS  = 1;
  localparam int TICK_CYCLES   = TICK_TIME_MS * CLK_FREQ_KHZ;
  localparam int PULSE_TIME_MS = 2;
  localparam int PULSE_CYCLES  = PULSE_TIME_MS * CLK_FREQ_KHZ;
  localparam int CNT_W         = 16;
  // command word layout
  localparam int WORD_W        = 16;
  localparam int CMD_DIR_BIT   = 15;
  localparam int CMD_PAGE_MSB  = 14;
  localparam int CMD_PAGE_LSB  = 11;
  localparam int CMD_IDX_MSB   = 10;
  localparam int CMD_IDX_LSB   = 5;
  localparam int PAGE_W        = 4;
  localparam int IDX_W         = 6;
  localparam int RES_W         = 12;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'hF;
  // pages
  localparam logic [3:0] PAGE_RESULT = 4'h0;
  localparam logic [3:0] PAGE_AUXCTL = 4'h1;
  localparam logic [3:0] PAGE_AUDIO  = 4'h2;
  localparam logic [3:0] PAGE_BUFFER = 4'h3;
  // page 0 result indices
  localparam logic [5:0] IDX_BAT   = 6'h05;
  localparam logic [5:0] IDX_AUX_INPUT_ONE  = 6'h07;
  localparam logic [5:0] IDX_AUX_INPUT_TWO  = 6'h08;
  localparam logic [5:0] IDX_TEMP_RESULT_ONE = 6'h09;
  localparam logic [5:0] IDX_TEMP_RESULT_TWO = 6'h0A;
  // page 1 control indices
  localparam logic [5:0] IDX_ADC      = 6'h00;
  localparam logic [5:0] IDX_BUFMODE  = 6'h02;
  localparam logic [5:0] IDX_AUX_INPUT_ONE_MAX = 6'h08;
  localparam logic [5:0] IDX_AUX_INPUT_ONE_MIN = 6'h09;
  localparam logic [5:0] IDX_AUX_INPUT_TWO_MAX = 6'h0A;
  localparam logic [5:0] IDX_AUX_INPUT_TWO_MIN = 6'h0B;
  localparam logic [5:0] IDX_MEASCFG  = 6'h0C;
  localparam logic [5:0] IDX_DELAY    = 6'h0D;
  // control fields
  localparam int SEL_MSB        = 12;
  localparam int SEL_LSB        = 10;
  localparam int BUF_EN_BIT     = 15;
  localparam int BUF_CONT_BIT   = 14;
  localparam int BUF_RESET_BIT  = 13;
  localparam int BUF_EMPTY_BIT  = 12;
  localparam int BUF_FULL_BIT   = 11;
  localparam int TRIG_MSB       = 5;
  localparam int TRIG_LSB       = 0;
  localparam int AUTO_EN_BIT    = 15;
  localparam int THR_IRQ_EN_BIT = 9;
  localparam int OOR_FLAG_BIT   = 8;
  localparam int DELAY_MSB      = 7;
  localparam int DELAY_LSB      = 0;
  localparam int FIFO_EMPTY_BIT = 15;
  localparam int FIFO_FULL_BIT  = 14;
  // fifo
  localparam int FIFO_DEPTH          = 64;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h40;
  localparam logic [5:0] FIFO_INIT_IDX = 6'h01;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    SRC_NONE  = 3'b000,
    SRC_BAT   = 3'b001,
    SRC_AUX_INPUT_ONE  = 3'b010,
    SRC_AUX_INPUT_TWO  = 3'b011,
    SRC_TEMP_RESULT_ONE = 3'b100,
    SRC_TEMP_RESULT_TWO = 3'b101,
    SRC_SCAN  = 3'b110
  } sac_src_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b10
  } sac_seq_t;

  typedef struct packed {
    logic        wr;
    logic [3:0]  page;
    logic [6:0]  idx;
    logic [15:0] data;
  } sac_req_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } sac_result_t;

  // index bit 6 marks "past the page end" and sticks there
  function automatic logic [6:0] sac_idx_inc(input logic [6:0] idx);
    sac_idx_inc = idx[IDX_W] ? idx : idx + 7'h01;
  endfunction : sac_idx_inc
endpackage : sac_pkg
